// *** cls_sched.v ***
// What this block does
// - Each of ten steps drives its own step output, numbered in step order.
// - A counter setting equals the entry times 100; entry 0.01 counts one.
// - Digital output terminals refresh only once per 5 ms.
// - Route step selectors take 0 (unused) or 1 to 10; reset 0.
// - Route function selectors take 0-100 and 1000-1081; reset 100.
// - Function selectors refuse 19, 1019, 80 and 1080.
// - One processing cycle every 2 ms: latch, evaluate, update.
// - All external step inputs are latched together at cycle start.
// - Steps are evaluated in order from step one to step ten.
// - Earlier outputs feed later steps same cycle; later ones next cycle.
// - All five routed outputs update together at cycle end.
// - Monitor step selector takes 1 to 10 and resets to 1.
// - Selected step timer value is readable on a monitor item.
// - Engine disable command makes the engine invalid while on.
// - Timer clear command holds all timers and counters at zero.
`include "cls_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module cls_sched #(
  parameter integer CYCLE_CLKS   = `CLS_CYCLE_CLKS,
  parameter integer REFRESH_CLKS = `CLS_DO_REFRESH_CLKS
) (
  input  wire         ref_clk,
  input  wire         rst_n,
  input  wire         engine_enable,
  input  wire         engine_disable_cmd,
  input  wire         timer_clear_cmd,
  input  wire [9:0]   ext_in,
  input  wire [39:0]  step_src,
  input  wire [159:0] step_time,
  input  wire         par_req,
  input  wire         par_we,
  input  wire [15:0]  par_num,
  input  wire [15:0]  par_wdata,
  output reg          par_ack,
  output reg          par_err,
  output reg  [15:0]  par_rdata,
  output wire [9:0]   step_out,
  output reg  [4:0]   routed_out,
  output wire [79:0]  route_func,
  output wire [4:0]   digital_output_terminal,
  output reg  [15:0]  mon_value,
  output wire         engine_valid
);

  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  localparam [1:0] ST_WAIT = 2'd0;
  localparam [1:0] ST_EVAL = 2'd1;
  localparam [1:0] ST_UPD  = 2'd2;

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  reg  [11:0] sync1_r;
  reg  [11:0] sync2_r;
  wire [9:0]  ext_s     = sync2_r[9:0];
  wire        disable_s = sync2_r[10];
  wire        clear_s   = sync2_r[11];

  // Two flip-flops for the external step inputs and the disable and clear commands; engine_enable is used directly.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 12'h000;
      sync2_r <= 12'h000;
    end else begin
      sync1_r <= {timer_clear_cmd, engine_disable_cmd, ext_in};
      sync2_r <= sync1_r;
    end
  end

  // Engine runs only while enabled and not cancelled.
  assign engine_valid = engine_enable & ~disable_s;

  // --------------------------------------------------------------------------
  // Parameter registers
  // --------------------------------------------------------------------------
  reg [15:0] step_sel_r [0:4];
  reg [15:0] func_sel_r [0:4];
  reg [15:0] mon_sel_r;

  // Function code check against the allowed set minus the refused codes.
  function func_ok;
    input [15:0] c;
    begin
      func_ok = ((c <= `CLS_FUNC_LOW_MAX) ||
                 ((c >= `CLS_FUNC_HIGH_MIN) && (c <= `CLS_FUNC_HIGH_MAX))) &&
                (c != `CLS_FUNC_KEYPAD_EDIT) && (c != `CLS_FUNC_KEYPAD_EDIT2) &&
                (c != `CLS_FUNC_ENG_DISABLE) && (c != `CLS_FUNC_ENG_DISABLE2);
    end
  endfunction

  reg [15:0] tmr_r [0:9];
  reg        hit;
  reg        ok;
  reg [15:0] rdat;
  // Each process walks its own loop index, so no variable has two drivers.
  integer    i;
  integer    ri;
  integer    si;

  // Parameter decode: finds the addressed item, its read data and legality.
  always @* begin
    hit  = 1'b0;
    ok   = 1'b0;
    rdat = 16'h0000;
    for (i = 0; i < 5; i = i + 1) begin
      if (par_num == `CLS_PAR_STEP_SEL_BASE + i[15:0]) begin
        hit  = 1'b1;
        rdat = step_sel_r[i];
        ok   = (par_wdata <= `CLS_STEP_SEL_MAX);
      end else if (par_num == `CLS_PAR_FUNC_SEL_BASE + i[15:0]) begin
        hit  = 1'b1;
        rdat = func_sel_r[i];
        ok   = func_ok(par_wdata);
      end
    end
    if (par_num == `CLS_PAR_MON_SEL) begin
      hit  = 1'b1;
      rdat = mon_sel_r;
      ok   = (par_wdata >= `CLS_MON_SEL_MIN) && (par_wdata <= `CLS_STEP_SEL_MAX);
    end else if (par_num == `CLS_PAR_MON_ITEM) begin
      hit  = 1'b1;
      rdat = mon_value;
      ok   = 1'b0;
    end
  end

  // Register writes, reads and their one-cycle answer.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (ri = 0; ri < 5; ri = ri + 1) begin
        step_sel_r[ri] <= `CLS_STEP_SEL_RST;
        func_sel_r[ri] <= `CLS_FUNC_SEL_RST;
      end
      mon_sel_r <= `CLS_MON_SEL_RST;
      par_ack   <= 1'b0;
      par_err   <= 1'b0;
      par_rdata <= 16'h0000;
    end else begin
      par_ack <= par_req;
      par_err <= par_req & (~hit | (par_we & ~ok));
      if (par_req && !par_we) begin
        par_rdata <= rdat;
      end
      if (par_req && par_we && ok) begin
        for (ri = 0; ri < 5; ri = ri + 1) begin
          if (par_num == `CLS_PAR_STEP_SEL_BASE + ri[15:0]) begin
            step_sel_r[ri] <= par_wdata;
          end else if (par_num == `CLS_PAR_FUNC_SEL_BASE + ri[15:0]) begin
            func_sel_r[ri] <= par_wdata;
          end
        end
        if (par_num == `CLS_PAR_MON_SEL) begin
          mon_sel_r <= par_wdata;
        end
      end
    end
  end

  // Function selectors go out as the sequence function of each route.
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_func
      assign route_func[16*g +: 16] = func_sel_r[g];
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Processing cycle scheduler
  // --------------------------------------------------------------------------
  reg [31:0] cyc_r;
  reg [1:0]  state_r;
  reg [3:0]  idx_r;
  reg [9:0]  ext_lat_r;
  reg [9:0]  so_r;

  wire       tick = (cyc_r == CYCLE_CLKS - 1);

  // Free-running cycle timer; one tick per processing cycle.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_r <= 32'h0000_0000;
    end else if (tick) begin
      cyc_r <= 32'h0000_0000;
    end else begin
      cyc_r <= cyc_r + 32'h0000_0001;
    end
  end

  // Input of the step under evaluation: a latched pin or a step output.
  // Earlier steps already hold this cycle's result, later ones last cycle's.
  wire [3:0]  src_sel = step_src[4*idx_r +: 4];
  wire        cur_in  = (src_sel == 4'h0 || src_sel > 4'ha) ? ext_lat_r[idx_r] :
                        so_r[src_sel - 4'h1];
  wire [15:0] cur_set = step_time[16*idx_r +: 16];
  wire        cur_out;
  wire [15:0] cur_tmr;

  cls_step_eval u_step (
    .in_bit  (cur_in),
    .tmr     (tmr_r[idx_r]),
    .setting (cur_set),
    .clear   (clear_s),
    .out_bit (cur_out),
    .tmr_nxt (cur_tmr)
  );

  // Latch, evaluate one step per clock, then update all routes.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= ST_WAIT;
      idx_r      <= 4'h0;
      ext_lat_r  <= 10'h000;
      so_r       <= 10'h000;
      routed_out <= 5'h00;
      for (si = 0; si < 10; si = si + 1) begin
        tmr_r[si] <= 16'h0000;
      end
    end else begin
      if (clear_s) begin
        for (si = 0; si < 10; si = si + 1) begin
          tmr_r[si] <= 16'h0000;
        end
      end
      case (state_r)
        ST_WAIT: begin
          if (tick) begin
            ext_lat_r <= ext_s;
            idx_r     <= 4'h0;
            state_r   <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          if (engine_valid) begin
            so_r[idx_r]  <= cur_out;
            tmr_r[idx_r] <= cur_tmr;
          end else begin
            so_r[idx_r]  <= 1'b0;
            tmr_r[idx_r] <= 16'h0000;
          end
          if (idx_r == 4'h9) begin
            state_r <= ST_UPD;
          end else begin
            idx_r <= idx_r + 4'h1;
          end
        end
        ST_UPD: begin
          // Selectors above ten are refused on write, so the index stays in range.
          for (si = 0; si < 5; si = si + 1) begin
            if (!engine_valid || step_sel_r[si] == 16'h0000 ||
                step_sel_r[si] > `CLS_STEP_SEL_MAX) begin
              routed_out[si] <= 1'b0;
            end else begin
              routed_out[si] <= so_r[step_sel_r[si][3:0] - 4'h1];
            end
          end
          state_r <= ST_WAIT;
        end
        default: begin
          state_r <= ST_WAIT;
        end
      endcase
    end
  end

  assign step_out = so_r;

  // --------------------------------------------------------------------------
  // Timer monitor
  // --------------------------------------------------------------------------
  // Shows the timer of the monitored step, refreshed every clock.
  // The selector never holds 0, since writes outside 1 to 10 are refused.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_value <= 16'h0000;
    end else begin
      mon_value <= tmr_r[mon_sel_r[3:0] - 4'h1];
    end
  end

  // --------------------------------------------------------------------------
  // Digital output terminals
  // --------------------------------------------------------------------------
  cls_do_refresh #(
    .REFRESH_CLKS (REFRESH_CLKS),
    .NUM          (5)
  ) u_do (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .src     (routed_out),
    .term    (digital_output_terminal)
  );

endmodule // cls_sched

`default_nettype wire

// *** cls_consts.vh ***
`ifndef CLS_CONSTS_VH
`define CLS_CONSTS_VH

// ----------------------------------------------------------------------------
// Parameter codes on the parameter port
// ----------------------------------------------------------------------------
// Route step selectors take five consecutive codes from this base.
`define CLS_PAR_STEP_SEL_BASE 16'h042f
// Route function selectors take five consecutive codes from this base.
`define CLS_PAR_FUNC_SEL_BASE 16'h0439
// Monitor step selector.
`define CLS_PAR_MON_SEL       16'h0443
// Read-only timer monitor item.
`define CLS_PAR_MON_ITEM      16'h0018

// ----------------------------------------------------------------------------
// Reset values and legal ranges
// ----------------------------------------------------------------------------
`define CLS_STEP_SEL_RST      16'h0000
`define CLS_STEP_SEL_MAX      16'h000a
`define CLS_FUNC_SEL_RST      16'h0064
`define CLS_FUNC_LOW_MAX      16'h0064
`define CLS_FUNC_HIGH_MIN     16'h03e8
`define CLS_FUNC_HIGH_MAX     16'h0439
`define CLS_FUNC_KEYPAD_EDIT  16'h0013
`define CLS_FUNC_KEYPAD_EDIT2 16'h03fb
`define CLS_FUNC_ENG_DISABLE  16'h0050
`define CLS_FUNC_ENG_DISABLE2 16'h0438
`define CLS_MON_SEL_RST       16'h0001
`define CLS_MON_SEL_MIN       16'h0001

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLS_CLK_MHZ           40
`define CLS_CYCLE_US          2000
`define CLS_CYCLE_CLKS        (`CLS_CYCLE_US * `CLS_CLK_MHZ)
`define CLS_DO_REFRESH_US     5000
`define CLS_DO_REFRESH_CLKS   (`CLS_DO_REFRESH_US * `CLS_CLK_MHZ)

`endif

// *** cls_step_eval.v ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// One step of the logic engine
// ----------------------------------------------------------------------------
// On-delay step: the output turns on once the input has been on for the
// setting, counted in processing cycles. The setting is entered in units of
// 0.01, and the count equals the entry times 100, so the raw integer is used.
module cls_step_eval (
  input  wire        in_bit,
  input  wire [15:0] tmr,
  input  wire [15:0] setting,
  input  wire        clear,
  output reg         out_bit,
  output reg  [15:0] tmr_nxt
);

  // Timer advance and output decision.
  always @* begin
    tmr_nxt = 16'h0000;
    out_bit = 1'b0;
    if (clear) begin
      tmr_nxt = 16'h0000;
      out_bit = 1'b0;
    end else if (in_bit) begin
      tmr_nxt = (tmr < setting) ? tmr + 16'h0001 : tmr;
      out_bit = (tmr_nxt >= setting);
    end
  end

endmodule // cls_step_eval

`default_nettype wire

// *** cls_do_refresh.v ***
`include "cls_consts.vh"
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Digital output terminal refresh
// ----------------------------------------------------------------------------
// Terminals are copied from the routed outputs only once per refresh period,
// so any pulse shorter than the period can be missed.
module cls_do_refresh #(
  parameter integer REFRESH_CLKS = `CLS_DO_REFRESH_CLKS,
  parameter integer NUM          = 5
) (
  input  wire           ref_clk,
  input  wire           rst_n,
  input  wire [NUM-1:0] src,
  output reg  [NUM-1:0] term
);

  reg [31:0] cnt_r;

  // Refresh timer and terminal snapshot.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 32'h0000_0000;
      term  <= {NUM{1'b0}};
    end else if (cnt_r == REFRESH_CLKS - 1) begin
      cnt_r <= 32'h0000_0000;
      term  <= src;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end

endmodule // cls_do_refresh

`default_nettype wire

// *** cls_sched_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------------
// Port checker for the output scheduler
// -----------------------------------------------------------------------
module cls_sched_checker #(
  parameter integer CYCLE_CLKS   = 40,
  parameter integer REFRESH_CLKS = 100
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        engine_disable_cmd,
  input wire logic        par_req,
  input wire logic        par_we,
  input wire logic [15:0] par_num,
  input wire logic [15:0] par_wdata,
  input wire logic        par_ack,
  input wire logic        par_err,
  input wire logic        engine_valid,
  input wire logic [9:0]  step_out,
  input wire logic [4:0]  routed_out,
  input wire logic [4:0]  digital_output_terminal
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Decoded write requests per selector group.
  wire logic wr = par_req && par_we;
  wire logic ss = par_num >= 16'h042f && par_num <= 16'h0433;
  wire logic fs = par_num >= 16'h0439 && par_num <= 16'h043d;
  wire logic [15:0] d = par_wdata;
  logic [31:0] tc_r;
  logic [4:0]  tq_r;
  logic [31:0] inv_r;
  // Counts clocks since the terminals last changed, and clocks spent invalid.
  // Step outputs only clear at their next evaluation and routed outputs at the next update, so invalid must outlast a full cycle.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tc_r  <= 32'h0;
      tq_r  <= 5'h00;
      inv_r <= 32'h0;
    end else begin
      inv_r <= engine_valid ? 32'h0 : inv_r + 32'h1;
      tq_r <= digital_output_terminal;
      tc_r <= (digital_output_terminal != tq_r) ? 32'h0 : tc_r + 32'h1;
    end
  end
  property p_ack; par_req |=> par_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  property p_step_bad; wr && ss && d > 16'h000a |=> par_err; endproperty
  a_step_bad: assert property (p_step_bad) else $error("bad step accepted");
  property p_step_ok; wr && ss && d <= 16'h000a |=> par_ack && !par_err; endproperty
  a_step_ok: assert property (p_step_ok) else $error("good step refused");
  property p_func_bad;
    wr && fs && (d == 16'h0013 || d == 16'h03fb || d == 16'h0050 || d == 16'h0438) |=> par_err;
  endproperty
  a_func_bad: assert property (p_func_bad) else $error("banned code accepted");
  property p_func_gap; wr && fs && d > 16'h0064 && d < 16'h03e8 |=> par_err; endproperty
  a_func_gap: assert property (p_func_gap) else $error("gap code accepted");
  property p_mon_bad; wr && par_num == 16'h0443 && (d == 16'h0 || d > 16'h000a) |=> par_err;
  endproperty
  a_mon_bad: assert property (p_mon_bad) else $error("bad monitor step accepted");
  property p_mon_ro; wr && par_num == 16'h0018 |=> par_err; endproperty
  a_mon_ro: assert property (p_mon_ro) else $error("monitor item written");
  property p_inv; inv_r >= CYCLE_CLKS + 14 |-> routed_out == 5'h00 && step_out == 10'h000;
  endproperty
  a_inv: assert property (p_inv) else $error("outputs active while invalid");
  property p_dis; engine_disable_cmd [*3] |-> !engine_valid; endproperty
  a_dis: assert property (p_dis) else $error("engine valid while disabled");
  property p_term; digital_output_terminal != tq_r |-> tc_r >= REFRESH_CLKS - 2; endproperty
  a_term: assert property (p_term) else $error("terminals refreshed too soon");
  c_err: cover property (par_ack && par_err);
  c_route: cover property (routed_out != 5'h00);
  c_term: cover property (digital_output_terminal != 5'h00);
endmodule // cls_sched_checker
bind cls_sched cls_sched_checker #(.CYCLE_CLKS(CYCLE_CLKS), .REFRESH_CLKS(REFRESH_CLKS))
  i_cls_sched_checker (
  .ref_clk, .rst_n, .engine_disable_cmd, .par_req, .par_we, .par_num, .par_wdata, .par_ack,
  .par_err, .engine_valid, .step_out, .routed_out, .digital_output_terminal);
`default_nettype wire

// *** cls_seq_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Sequence processor inputs: a route counts only while a function is assigned.
module cls_seq_model (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  routed_out,
  input  wire logic [79:0] route_func,
  output var  logic [4:0]  seq_in
);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) seq_in <= 5'h00;
    else for (int r = 0; r < 5; r++) seq_in[r] <= routed_out[r] && route_func[16*r+:16] != 16'h0064;
  end
endmodule // cls_seq_model
`default_nettype wire

// *** test_custom_logic_output_scheduler.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_custom_logic_output_scheduler;
  logic ref_clk = 0, rst_n = 0, engine_enable = 1, engine_disable_cmd = 0, timer_clear_cmd = 0;
  logic par_req = 0, par_we = 0, er;
  logic [9:0]   ext_in = 10'h000;
  logic [15:0]  par_num = 16'h0, par_wdata = 16'h0, rd;
  logic [39:0]  step_src = 40'h0;
  logic [159:0] step_time = {16'h0003, 144'h0};
  wire logic par_ack, par_err, engine_valid;
  wire logic [15:0] par_rdata, mon_value;
  wire logic [9:0]  step_out;
  wire logic [4:0]  routed_out, digital_output_terminal, seq_in;
  wire logic [79:0] route_func;
  integer fails = 0, n_checks = 0, cyc = 0, i, j, v, src[10], tmr[10], sout[10], rg[11];
  integer tv[12] = '{0, 10, 11, 19, 80, 1019, 1080, 100, 101, 1000, 1081, 1082};
  cls_sched #(.CYCLE_CLKS(40), .REFRESH_CLKS(100)) i_cls_sched (.ref_clk, .rst_n,
    .engine_enable, .engine_disable_cmd, .timer_clear_cmd, .ext_in, .step_src, .step_time,
    .par_req, .par_we, .par_num, .par_wdata, .par_ack, .par_err, .par_rdata, .step_out,
    .routed_out, .route_func, .digital_output_terminal, .mon_value, .engine_valid);
  cls_seq_model i_cls_seq_model (.ref_clk, .rst_n, .routed_out, .route_func, .seq_in);
  initial forever #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (rst_n) cyc <= cyc + 1;
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One parameter access; waits for the ack under a bound.
  task automatic par(input logic w, input logic [15:0] n, input logic [15:0] dv);
    integer t;
    @(negedge ref_clk); par_req = 1; par_we = w; par_num = n; par_wdata = dv;
    @(negedge ref_clk); par_req = 0;
    t = 0;
    while (par_ack !== 1'b1 && t < 4) begin @(negedge ref_clk); t++; end
    if (t == 4) begin
      fails++;
      $display("mismatch par_ack expected 1 seen 0");
      final_report();
    end
    rd = par_rdata; er = par_err;
  endtask
  function automatic bit legal(integer r, integer x);
    if (r < 5) return x >= 0 && x <= 10;
    if (r < 10) return (x <= 100 || (x >= 1000 && x <= 1081)) && x != 19 && x != 1019 &&
      x != 80 && x != 1080;
    return x >= 1 && x <= 10;
  endfunction
  function automatic logic [15:0] code(integer r);
    return r < 5 ? 16'h042f + r : r < 10 ? 16'h0439 + r - 5 : 16'h0443;
  endfunction
  // Reference engine: steps in order, earlier results feed later steps.
  task automatic mdl;
    integer k, x, s;
    for (k = 0; k < 10; k++) begin
      x = src[k] == 0 ? ext_in[k] : sout[src[k]-1];
      s = k == 9 ? 3 : 0;
      if (!engine_enable || engine_disable_cmd || timer_clear_cmd || !x) begin
        tmr[k] = 0; sout[k] = 0;
      end else begin
        if (tmr[k] < s) tmr[k]++;
        sout[k] = tmr[k] >= s;
      end
    end
  endtask
  // One engine cycle with new inputs, then compare the results; the terminals only when term is set.
  task automatic estep(input logic [9:0] x, input bit term);
    integer r;
    logic [31:0] e;
    ext_in = x;
    mdl();
    repeat (20) @(negedge ref_clk);
    ext_in = ~x;
    repeat (20) @(negedge ref_clk);
    e = 0;
    for (r = 0; r < 5; r++) if (rg[r] != 0) e[r] = sout[rg[r]-1][0];
    chk("routed", e, routed_out);
    if (term) chk("term", e, digital_output_terminal);
    for (r = 0; r < 5; r++) if (rg[5+r] == 100) e[r] = 1'b0;
    chk("seq", e, seq_in);
    e = 0;
    for (r = 0; r < 10; r++) e[r] = sout[r][0];
    chk("step", e, step_out);
    chk("mon", tmr[9], mon_value);
    chk("valid", engine_enable && !engine_disable_cmd, engine_valid);
  endtask
  initial begin
    void'($urandom(32'h18cf));
    repeat (10) @(negedge ref_clk);
    rst_n = 1;
    for (i = 0; i < 11; i++) begin
      rg[i] = i < 5 ? 0 : i < 10 ? 100 : 1;
      par(0, code(i), 16'h0);
      chk("reset", rg[i], rd);
    end
    for (i = 0; i < 11; i++) for (j = 0; j < 13; j++) begin
      v = j < 12 ? tv[j] : $urandom % 1100;
      par(1, code(i), v[15:0]);
      chk("werr", !legal(i, v), er);
      if (legal(i, v)) rg[i] = v;
      par(0, code(i), 16'h0);
      chk("rd", rg[i], rd);
    end
    chk("func", rg[9], route_func[79:64]);
    par(1, 16'h0018, 16'h0005);
    chk("ro", 1, er);
    $display("test registers done");
    step_src = {36'h0, 4'h2} | (40'h2 << 8);
    for (i = 0; i < 10; i++) begin src[i] = step_src[4*i+:4]; tmr[i] = 0; sout[i] = 0; end
    rg[0] = 1; rg[1] = 3; rg[2] = 0; rg[3] = 5; rg[4] = 10; rg[10] = 10;
    for (i = 0; i < 5; i++) par(1, code(i), rg[i][15:0]);
    par(1, code(10), 16'h000a);
    for (j = 0; j < 40 && cyc % 40 != 20; j++) @(negedge ref_clk);
    for (i = 0; i < 44; i++) begin
      engine_disable_cmd = i >= 30 && i < 33;
      timer_clear_cmd = i >= 33 && i < 36;
      engine_enable = !(i >= 36 && i < 38);
      estep(i < 38 ? 10'($urandom) : 10'h3ff, i == 43);
    end
    $display("test engine done");
    final_report();
  end
endmodule // test_custom_logic_output_scheduler
`default_nettype wire
